// ---- design/cfs_pkg.sv ----
// Purpose: shared constants and types for the can node fault supervisor
// Assumes: 40 MHz core clock
// Notes: mode codes and fault carrier struct
package cfs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned THERMAL_RECHECK_MS = 300;
  localparam int unsigned THERMAL_RECHECK_CYC = THERMAL_RECHECK_MS * (CLK_HZ / 1000);
  localparam int unsigned DOMINANT_TIMEOUT_CYC = 40_000;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic PULL_HIGH = 1'b1;
  localparam logic PULL_LOW = 1'b0;

  typedef enum logic [2:0] {
    CFS_NORMAL = 3'b000,
    CFS_STANDBY = 3'b001,
    CFS_SLEEP = 3'b010,
    CFS_THERMAL = 3'b011,
    CFS_UV_PROT = 3'b100
  } cfs_state_e;

  typedef struct packed {
    logic supply_undervoltage;
    logic io_rail_undervoltage;
    logic regulator_undervoltage;
    logic thermal_shutdown;
    logic power_on_reset;
  } cfs_faults_s;
endpackage

// ---- design/cfs_supervisor.sv ----
// Purpose: fault supervision: dominant timeout, thermal shutdown, undervoltage handling
// Assumes: analog detectors arrive asynchronously and are synchronised here
// Notes: mode requests are one-cycle pulses from the register logic
`timescale 1ns/1ps
// Functional notes
// - falling transmit edge starts dominant timer
// - timer expiry disables bus driver
// - recessive transmit re-enables driver, clears fault
// - receiver stays on, bus biased recessive
// - thermal fault switches off transceiver regulator
// - thermal fault sets flag, asserts interrupt
// - core and host interface stay active
// - 300 ms recheck, cool goes standby
// - thermal mode accepts only sleep writes
// - thermal during io undervoltage enters sleep
// - supply or io undervoltage protects bus
// - supply undervoltage blocks host, bus signals
// - supply undervoltage flags, regulator off, standby
// - supply recovery enters standby
// - power-on-reset clears all, host reconfigures
// - floating host inputs default to safe levels
// - forced standby sets init, normal clears
module cfs_supervisor import cfs_pkg::*; #(
  parameter int unsigned DOM_TIMEOUT_CYC = DOMINANT_TIMEOUT_CYC,
  parameter int unsigned RECHECK_CYC = THERMAL_RECHECK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tx_line,
  input wire logic i_bus_rx,
  input wire logic i_bus_wake,
  input wire cfs_faults_s i_faults_async,
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode_req,
  input wire logic i_flag_clear,
  output logic o_driver_en,
  output logic o_bias_recessive,
  output logic o_rx_line,
  output logic o_regulator_en,
  output logic o_thermal_flag,
  output logic o_regulator_uv_flag,
  output logic o_interrupt,
  output logic o_host_if_en,
  output logic o_bus_wake_indication,
  output logic o_core_init_bit,
  output logic o_clear_registers,
  output logic [1:0] o_mode,
  output logic o_dominant_timeout,
  output logic o_chip_select_low_pull,
  output logic o_sclk_pull,
  output logic o_sdi_pull,
  output logic o_reset_pull
);
  cfs_faults_s sync1_reg, sync2_reg;
  logic tx_meta_reg, tx_sync_reg, tx_prev_reg;
  logic [31:0] dom_cnt_reg;
  logic dto_reg;
  logic [31:0] rchk_cnt_reg;
  cfs_state_e state_reg, state_next;
  logic tflag_reg, uvflag_reg, init_reg, rx_reg, wake_reg, clr_reg;
  logic tsd_rise, uv_rise, por;
  logic rx_meta_reg, rx_sync_reg, wake_meta_reg, wake_sync_reg;

  always_ff @(posedge i_clk) begin
    sync1_reg <= i_faults_async;
    sync2_reg <= sync1_reg;
    tx_meta_reg <= i_tx_line;
    tx_sync_reg <= tx_meta_reg;
    tx_prev_reg <= tx_sync_reg;
    rx_meta_reg <= i_bus_rx;
    rx_sync_reg <= rx_meta_reg;
    wake_meta_reg <= i_bus_wake;
    wake_sync_reg <= wake_meta_reg;
  end

  logic tsd_prev_reg, uv_prev_reg;
  always_ff @(posedge i_clk) begin
    tsd_prev_reg <= sync2_reg.thermal_shutdown;
    uv_prev_reg <= sync2_reg.supply_undervoltage;
  end
  assign tsd_rise = sync2_reg.thermal_shutdown & ~tsd_prev_reg;
  assign uv_rise = sync2_reg.supply_undervoltage & ~uv_prev_reg;
  assign por = sync2_reg.power_on_reset;

  // dominant timeout counter
  always_ff @(posedge i_clk) begin
    if (i_rst || por) begin
      dom_cnt_reg <= '0;
      dto_reg <= 1'b0;
    end else if (tx_sync_reg) begin
      dom_cnt_reg <= '0;
      dto_reg <= 1'b0;
    end else if (tx_prev_reg) begin
      dom_cnt_reg <= 32'h0000_0001;
    end else if (!dto_reg) begin
      if (dom_cnt_reg >= DOM_TIMEOUT_CYC) begin
        dto_reg <= 1'b1;
      end else begin
        dom_cnt_reg <= dom_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // thermal recheck timer
  always_ff @(posedge i_clk) begin
    if (i_rst || por || state_reg != CFS_THERMAL) begin
      rchk_cnt_reg <= '0;
    end else if (rchk_cnt_reg < RECHECK_CYC) begin
      rchk_cnt_reg <= rchk_cnt_reg + 32'h0000_0001;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CFS_NORMAL, CFS_STANDBY, CFS_SLEEP: begin
        if (i_mode_wr) begin
          case (i_mode_req)
            MODE_NORMAL: state_next = CFS_NORMAL;
            MODE_SLEEP: state_next = CFS_SLEEP;
            default: state_next = CFS_STANDBY;
          endcase
        end
      end
      CFS_THERMAL: begin
        if (sync2_reg.io_rail_undervoltage) begin
          state_next = CFS_SLEEP;
        end else if (i_mode_wr && i_mode_req == MODE_SLEEP) begin
          state_next = CFS_SLEEP;
        end else if (rchk_cnt_reg >= RECHECK_CYC && !sync2_reg.thermal_shutdown) begin
          state_next = CFS_STANDBY;
        end
      end
      CFS_UV_PROT: begin
        if (!sync2_reg.supply_undervoltage) begin
          state_next = CFS_STANDBY;
        end
      end
      default: state_next = CFS_STANDBY;
    endcase
    if (sync2_reg.supply_undervoltage) begin
      state_next = CFS_UV_PROT;
    end else if (tsd_rise) begin
      state_next = sync2_reg.io_rail_undervoltage ? CFS_SLEEP : CFS_THERMAL;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || por) begin
      state_reg <= CFS_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_rst || por) begin
      tflag_reg <= 1'b0;
      uvflag_reg <= 1'b0;
    end else begin
      tflag_reg <= tsd_rise | (tflag_reg & ~i_flag_clear);
      uvflag_reg <= uv_rise | (uvflag_reg & ~i_flag_clear);
    end
  end

  // core init bit on forced normal-to-standby
  always_ff @(posedge i_clk) begin
    if (i_rst || por) begin
      init_reg <= 1'b0;
    end else if (state_reg == CFS_NORMAL && state_next != CFS_NORMAL
                 && (uv_rise || tsd_rise || sync2_reg.regulator_undervoltage)) begin
      init_reg <= 1'b1;
    end else if (state_reg != CFS_NORMAL && state_next == CFS_NORMAL) begin
      init_reg <= 1'b0;
    end
  end

  // bus-derived outputs blocked in supply undervoltage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_reg <= 1'b1;
      wake_reg <= 1'b0;
      clr_reg <= 1'b1;
    end else begin
      rx_reg <= (state_reg == CFS_UV_PROT) ? 1'b1 : rx_sync_reg;
      wake_reg <= (state_reg == CFS_UV_PROT) ? 1'b0 : wake_sync_reg;
      clr_reg <= por;
    end
  end

  assign o_rx_line = rx_reg;
  assign o_bus_wake_indication = wake_reg;
  assign o_clear_registers = clr_reg;
  assign o_driver_en = (state_reg == CFS_NORMAL) && !dto_reg
                       && !sync2_reg.regulator_undervoltage
                       && !sync2_reg.io_rail_undervoltage;
  assign o_bias_recessive = (state_reg == CFS_NORMAL);
  assign o_regulator_en = (state_reg != CFS_THERMAL) && (state_reg != CFS_UV_PROT);
  assign o_thermal_flag = tflag_reg;
  assign o_regulator_uv_flag = uvflag_reg;
  assign o_interrupt = tflag_reg | uvflag_reg;
  assign o_host_if_en = (state_reg != CFS_UV_PROT);
  assign o_core_init_bit = init_reg;
  assign o_dominant_timeout = dto_reg;
  assign o_mode = (state_reg == CFS_NORMAL) ? MODE_NORMAL :
                  (state_reg == CFS_SLEEP) ? MODE_SLEEP : MODE_STANDBY;
  assign o_chip_select_low_pull = PULL_HIGH;
  assign o_sclk_pull = PULL_HIGH;
  assign o_sdi_pull = PULL_HIGH;
  assign o_reset_pull = PULL_LOW;

  chk_dto_release: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_sync_reg |=> !dto_reg) else $error("timeout not cleared");
  chk_driver_off: assert property (@(posedge i_clk) disable iff (i_rst)
    dto_reg |-> !o_driver_en) else $error("driver on in timeout");
  chk_thermal_flag: assert property (@(posedge i_clk) disable iff (i_rst || por)
    tsd_rise |=> tflag_reg && o_interrupt) else $error("thermal flag missed");
  chk_thermal_reg: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == CFS_THERMAL |-> !o_regulator_en) else $error("regulator on");
  chk_uv_host: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == CFS_UV_PROT |-> !o_host_if_en) else $error("host if on");
  chk_uv_enter: assert property (@(posedge i_clk) disable iff (i_rst || por)
    sync2_reg.supply_undervoltage |=> state_reg == CFS_UV_PROT) else $error("no uv");
  chk_uv_recover: assert property (@(posedge i_clk) disable iff (i_rst || por)
    state_reg == CFS_UV_PROT && !sync2_reg.supply_undervoltage |=> state_reg == CFS_STANDBY)
    else $error("no recovery");
  chk_thermal_filter: assert property (@(posedge i_clk) disable iff (i_rst || por)
    state_reg == CFS_THERMAL && i_mode_wr && i_mode_req == MODE_NORMAL
    |=> state_reg != CFS_NORMAL) else $error("normal accepted");
  chk_init_exit: assert property (@(posedge i_clk) disable iff (i_rst || por)
    $rose(state_reg == CFS_NORMAL) |-> !init_reg) else $error("init stuck");

  sequence s_tx_fall;
    tx_prev_reg && !tx_sync_reg;
  endsequence
  sequence s_dom_held;
    !tx_sync_reg && !dto_reg;
  endsequence
  sequence s_recheck_done;
    state_reg == CFS_THERMAL && rchk_cnt_reg >= RECHECK_CYC && !sync2_reg.thermal_shutdown;
  endsequence

  chk_dto_start: assert property (@(posedge i_clk) disable iff (i_rst || por)
    s_tx_fall |=> dom_cnt_reg == 32'h0000_0001)
    else $error("timer not started");

  chk_dto_expire: assert property (@(posedge i_clk) disable iff (i_rst || por)
    s_dom_held ##0 (!tx_prev_reg && dom_cnt_reg >= DOM_TIMEOUT_CYC) |=> dto_reg)
    else $error("timeout not raised");

  chk_dto_early: assert property (@(posedge i_clk) disable iff (i_rst || por)
    !dto_reg && dom_cnt_reg < DOM_TIMEOUT_CYC |=> !dto_reg)
    else $error("timeout raised early");

  chk_dto_count: assert property (@(posedge i_clk) disable iff (i_rst || por)
    s_dom_held ##0 (!tx_prev_reg && dom_cnt_reg < DOM_TIMEOUT_CYC)
    |=> dom_cnt_reg == $past(dom_cnt_reg) + 32'h0000_0001) else $error("timer stalled");

  chk_bias_timeout: assert property (@(posedge i_clk) disable iff (i_rst)
    dto_reg && state_reg == CFS_NORMAL |-> o_bias_recessive)
    else $error("bias lost in timeout");

  chk_rx_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg != CFS_UV_PROT |=> o_rx_line == $past(rx_sync_reg))
    else $error("receiver not following");

  chk_rx_blocked: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == CFS_UV_PROT |=> o_rx_line)
    else $error("receive forwarded in uv");

  chk_wake_blocked: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == CFS_UV_PROT |=> !o_bus_wake_indication)
    else $error("wake forwarded in uv");

  chk_uv_regoff: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == CFS_UV_PROT |-> !o_regulator_en)
    else $error("regulator on in uv");

  chk_uv_flag: assert property (@(posedge i_clk) disable iff (i_rst || por)
    uv_rise |=> uvflag_reg)
    else $error("uv flag missed");

  chk_thermal_enter: assert property (@(posedge i_clk) disable iff (i_rst || por)
    tsd_rise && !sync2_reg.supply_undervoltage && !sync2_reg.io_rail_undervoltage
    |=> state_reg == CFS_THERMAL) else $error("thermal not entered");

  chk_thermal_io_sleep: assert property (@(posedge i_clk) disable iff (i_rst || por)
    tsd_rise && !sync2_reg.supply_undervoltage && sync2_reg.io_rail_undervoltage
    |=> state_reg == CFS_SLEEP) else $error("sleep not entered");

  chk_recheck_exit: assert property (@(posedge i_clk) disable iff (i_rst || por)
    s_recheck_done ##0 (!sync2_reg.supply_undervoltage && !sync2_reg.io_rail_undervoltage
    && !i_mode_wr) |=> state_reg == CFS_STANDBY) else $error("recheck exit missed");

  chk_recheck_hold: assert property (@(posedge i_clk) disable iff (i_rst || por)
    state_reg == CFS_THERMAL && rchk_cnt_reg < RECHECK_CYC && !sync2_reg.io_rail_undervoltage
    && !sync2_reg.supply_undervoltage && !i_mode_wr |=> state_reg == CFS_THERMAL) else $error("early exit");

  chk_thermal_sleep_wr: assert property (@(posedge i_clk) disable iff (i_rst || por)
    state_reg == CFS_THERMAL && i_mode_wr && i_mode_req == MODE_SLEEP && !tsd_rise
    && !sync2_reg.supply_undervoltage |=> state_reg == CFS_SLEEP) else $error("sleep refused");

  chk_thermal_stby_wr: assert property (@(posedge i_clk) disable iff (i_rst || por)
    state_reg == CFS_THERMAL && i_mode_wr && i_mode_req == MODE_STANDBY
    && rchk_cnt_reg < RECHECK_CYC |=> state_reg != CFS_STANDBY) else $error("standby accepted");

  chk_host_thermal: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == CFS_THERMAL |-> o_host_if_en)
    else $error("host if off in thermal");

  chk_por_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    por |=> o_clear_registers)
    else $error("clear not signalled");

  chk_por_state: assert property (@(posedge i_clk) disable iff (i_rst)
    por |=> state_reg == CFS_STANDBY && !tflag_reg && !uvflag_reg)
    else $error("state not cleared");

  chk_init_set: assert property (@(posedge i_clk) disable iff (i_rst || por)
    state_reg == CFS_NORMAL && (uv_rise || tsd_rise) |=> init_reg)
    else $error("init not set");

  chk_init_clear: assert property (@(posedge i_clk) disable iff (i_rst || por)
    state_reg != CFS_NORMAL && state_next == CFS_NORMAL |=> !init_reg)
    else $error("init not cleared");

  chk_drv_io_uv: assert property (@(posedge i_clk) disable iff (i_rst)
    sync2_reg.io_rail_undervoltage |-> !o_driver_en)
    else $error("driver on in io uv");

  chk_drv_reg_uv: assert property (@(posedge i_clk) disable iff (i_rst)
    sync2_reg.regulator_undervoltage |-> !o_driver_en)
    else $error("driver on in regulator uv");

  chk_uv_driver: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == CFS_UV_PROT |-> !o_driver_en)
    else $error("driver on in supply uv");

  chk_flag_clear: assert property (@(posedge i_clk) disable iff (i_rst || por)
    tflag_reg && i_flag_clear && !tsd_rise |=> !tflag_reg)
    else $error("flag not cleared");

  chk_irq_uv: assert property (@(posedge i_clk) disable iff (i_rst)
    uvflag_reg |-> o_interrupt)
    else $error("uv interrupt missing");
endmodule

// ---- test/cfs_can_core_model.sv ----
// Purpose: protocol-side model driving the internal transmit line
// Assumes: one bit time is BIT_CYC core cycles
// Notes: stick() models a stuck line for fault scenarios
`timescale 1ns/1ps
module cfs_can_core_model #(
  parameter int unsigned BIT_CYC = 1
) (
  input wire logic i_clk,
  output logic o_tx
);
  initial o_tx = 1'b1;
  // dominant run, capped, then one recessive bit
  task automatic send_run(input int unsigned n_bits);
    int unsigned n;
    n = (n_bits > 11) ? 11 : n_bits;
    @(posedge i_clk);
    #2 o_tx = 1'b0;
    repeat (n * BIT_CYC) @(posedge i_clk);
    #2 o_tx = 1'b1;
    repeat (BIT_CYC) @(posedge i_clk);
  endtask
  task automatic stick(input logic dom);
    @(posedge i_clk);
    #2 o_tx = ~dom;
  endtask
endmodule

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the fault supervisor
// Assumes: shortened dominant timeout and recheck counts
// Notes: random run lengths from a fixed seed
`timescale 1ns/1ps
module tb_top;
  import cfs_pkg::*;
  localparam int unsigned DOMINANT_TIMEOUT = 20;
  localparam int unsigned RCK = 50;
  logic i_clk = 1'b0, i_rst = 1'b1, i_bus_rx = 1'b1, i_bus_wake = 1'b0;
  logic i_mode_wr = 1'b0, i_flag_clear = 1'b0;
  logic [1:0] i_mode_req = MODE_STANDBY;
  cfs_faults_s flt = '0;
  wire logic tx;
  logic drv, bias, rx, reg_en, tf, uvf, irq, hif, bwi, init, clr, dominant_timeout, pcs, psc, psd, prs;
  logic [1:0] mode, m0;
  int miscompares = 0, n_compared = 0, k;
  always #12.5 i_clk = ~i_clk;
  cfs_can_core_model i_cfs_can_core_model (.i_clk(i_clk), .o_tx(tx));
  cfs_supervisor #(.DOM_TIMEOUT_CYC(DOMINANT_TIMEOUT), .RECHECK_CYC(RCK)) i_cfs_supervisor (
    .i_clk(i_clk), .i_rst(i_rst), .i_tx_line(tx), .i_bus_rx(i_bus_rx),
    .i_bus_wake(i_bus_wake), .i_faults_async(flt), .i_mode_wr(i_mode_wr),
    .i_mode_req(i_mode_req), .i_flag_clear(i_flag_clear), .o_driver_en(drv),
    .o_bias_recessive(bias), .o_rx_line(rx), .o_regulator_en(reg_en), .o_thermal_flag(tf),
    .o_regulator_uv_flag(uvf), .o_interrupt(irq), .o_host_if_en(hif),
    .o_bus_wake_indication(bwi), .o_core_init_bit(init), .o_clear_registers(clr),
    .o_mode(mode), .o_dominant_timeout(dominant_timeout), .o_chip_select_low_pull(pcs),
    .o_sclk_pull(psc), .o_sdi_pull(psd), .o_reset_pull(prs));
  task automatic print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // bounded wait for a design output to reach a level
  task automatic wait_on(ref logic s, input logic v, input int n);
    k = 0;
    while (s !== v && k < n) begin
      cyc(1);
      k++;
    end
    chk(s, v);
    if (s !== v) print_verdict();
  endtask
  task automatic wr_mode(input logic [1:0] m);
    @(posedge i_clk);
    #2 i_mode_wr = 1'b1;
    i_mode_req = m;
    cyc(1);
    i_mode_wr = 1'b0;
    cyc(1);
  endtask
  initial begin
    void'($urandom(32'hc8060e99));
    cyc(8);
    i_rst = 1'b0;
    chk(mode, MODE_STANDBY);
    chk({pcs, psc, psd, prs}, {PULL_HIGH, PULL_HIGH, PULL_HIGH, PULL_LOW});
    wr_mode(MODE_NORMAL);
    chk({mode, drv, init}, {MODE_NORMAL, 2'b10});
    repeat (6) begin
      i_cfs_can_core_model.send_run(1 + $urandom_range(10));
      chk({dominant_timeout, drv}, 2'b01);
    end
    i_cfs_can_core_model.stick(1'b1);
    wait_on(dominant_timeout, 1'b1, DOMINANT_TIMEOUT + 10);
    chk({k >= DOMINANT_TIMEOUT, drv, bias}, 3'b101);
    i_bus_rx = 1'b0;
    cyc(3);
    chk(rx, 1'b0);
    i_bus_rx = 1'b1;
    i_cfs_can_core_model.stick(1'b0);
    wait_on(dominant_timeout, 1'b0, 5);
    chk(drv, 1'b1);
    flt.thermal_shutdown = 1'b1;
    wait_on(tf, 1'b1, 6);
    chk({reg_en, irq, hif, init, drv}, 5'b01110);
    m0 = mode;
    wr_mode(MODE_NORMAL);
    wr_mode(MODE_STANDBY);
    chk({mode, reg_en}, {m0, 1'b0});
    flt.thermal_shutdown = 1'b0;
    wait_on(reg_en, 1'b1, RCK + 10);
    chk({mode, k >= RCK - 10}, {MODE_STANDBY, 1'b1});
    i_flag_clear = 1'b1;
    cyc(1);
    i_flag_clear = 1'b0;
    cyc(1);
    chk({tf, irq}, 2'b00);
    flt.thermal_shutdown = 1'b1;
    wait_on(tf, 1'b1, 6);
    wr_mode(MODE_SLEEP);
    chk(mode, MODE_SLEEP);
    flt = '{power_on_reset: 1'b1, default: 1'b0};
    wait_on(clr, 1'b1, 6);
    flt.power_on_reset = 1'b0;
    cyc(6);
    chk({mode, tf, uvf, clr}, {MODE_STANDBY, 3'b000});
    flt.io_rail_undervoltage = 1'b1;
    cyc(4);
    flt.thermal_shutdown = 1'b1;
    cyc(6);
    chk({mode, hif, drv}, {MODE_SLEEP, 2'b10});
    flt = '0;
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    wr_mode(MODE_NORMAL);
    i_bus_wake = 1'b1;
    flt.io_rail_undervoltage = 1'b1;
    cyc(3);
    chk(drv, 1'b0);
    flt.io_rail_undervoltage = 1'b0;
    cyc(3);
    chk({drv, bwi}, 2'b11);
    flt.supply_undervoltage = 1'b1;
    wait_on(uvf, 1'b1, 6);
    cyc(1);
    chk({hif, bwi, reg_en, drv, rx, init}, 6'b000011);
    flt.supply_undervoltage = 1'b0;
    cyc(6);
    chk(mode, MODE_STANDBY);
    wr_mode(MODE_NORMAL);
    chk({mode, init}, {MODE_NORMAL, 1'b0});
    print_verdict();
  end
endmodule
